/* inc/mrtu_pkg.sv */
// constants and shared functions of the serial slave port
package mrtu_pkg;
   localparam int          CLK_HZ   = 100_000_000;
   localparam int          BAUD_RST = 115_200;
   localparam int          BAUD_MAX = 10_500_000;
   localparam int          BAUD_MIN = 1_200;
   localparam logic [16:0] DIV_RST  = 17'(CLK_HZ / BAUD_RST);
   localparam logic [16:0] DIV_MIN  = 17'(CLK_HZ / BAUD_MAX);
   localparam logic [16:0] DIV_MAX  = 17'(CLK_HZ / BAUD_MIN);
   // frame gap of 3.5 characters, held in half characters
   localparam logic [3:0]  GAP_HALF = 4'h7;
   localparam logic [3:0]  SID_RST  = 4'h9;
   localparam logic [3:0]  SID_MAX  = 4'h9;
   localparam logic [1:0]  PAR_NONE = 2'h0;
   localparam logic [1:0]  PAR_ODD  = 2'h1;
   localparam logic [1:0]  PAR_EVEN = 2'h2;
   localparam logic [7:0]  FC_RD    = 8'h04;
   localparam logic [7:0]  FC_W1    = 8'h06;
   localparam logic [7:0]  FC_WN    = 8'h10;
   localparam logic [7:0]  FC_RW    = 8'h17;
   localparam logic [7:0]  EXC_FLAG = 8'h80;
   localparam logic [7:0]  EXC_VAL  = 8'h03;
   localparam logic [15:0] CMD_BASE = 16'h03E8;
   localparam logic [15:0] STS_BASE = 16'h07D0;
   localparam logic [15:0] NREG     = 16'h0008;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [5:0]  FB_LAST  = 6'h20;
   localparam logic [7:0]  A_CFG    = 8'h00;
   localparam logic [7:0]  A_DIV    = 8'h04;
   localparam logic [7:0]  A_CNT    = 8'h08;
   localparam logic [7:0]  A_STAT   = 8'h0C;
   localparam logic [2:0]  A_CMD    = 3'h2;
   localparam logic [2:0]  A_STS    = 3'h3;

   function automatic logic [15:0] crc_upd(input logic [15:0] c,
                                           input logic [7:0]  d);
      logic [15:0] x;
      x = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
      end
      return x;
   endfunction

   function automatic logic par_bit(input logic [7:0] d,
                                    input logic [1:0] p);
      return (p == PAR_ODD) ? ~^d : ^d;
   endfunction
endpackage

/* src/uart_char.sv */
// character transmitter and receiver of the serial line
`timescale 1ns/1ps
`default_nettype none
module uart_char
   import mrtu_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic [16:0] div_i,
   input  wire logic [1:0]  par_i,
   input  wire logic        stp2_i,
   input  wire logic        rx_i,
   output logic             rx_v_o,
   output logic [7:0]       rx_d_o,
   output logic             rx_err_o,
   output logic             rx_busy_o,
   input  wire logic        tx_go_i,
   input  wire logic [7:0]  tx_d_i,
   output logic             tx_busy_o,
   output logic             tx_o
);
   typedef struct packed {
      logic [2:0]  sy;
      logic        rl;
      logic        ron;
      logic [3:0]  rb;
      logic [16:0] rc;
      logic [10:0] rs;
      logic        rv;
      logic [7:0]  rd;
      logic        re;
      logic        ton;
      logic [3:0]  tb;
      logic [16:0] tc;
      logic [11:0] ts;
      logic        txo;
   } ph_t;

   ph_t        q_r;
   ph_t        q_nxt;
   logic       pen;
   logic [3:0] rn;
   logic [3:0] tn;

   always_comb begin
      pen = (par_i != PAR_NONE);
      rn = pen ? 4'hA : 4'h9;
      tn = 4'hA + {3'h0, pen} + {3'h0, stp2_i};
      q_nxt = q_r;
      q_nxt.rv = 1'b0;
      q_nxt.re = 1'b0;
      q_nxt.sy = {q_r.sy[1:0], rx_i};
      // a level change counts once the last two stages agree
      if (q_r.sy[1] == q_r.sy[2]) begin
         q_nxt.rl = q_r.sy[2];
      end
      if (!q_r.ron) begin
         if (!q_r.rl) begin
            q_nxt.ron = 1'b1;
            q_nxt.rb = 4'h0;
            q_nxt.rc = {1'b0, div_i[16:1]};
         end
      end else if (q_r.rc != 17'h0) begin
         q_nxt.rc = q_r.rc - 17'h1;
      end else begin
         q_nxt.rc = div_i - 17'h1;
         q_nxt.rs[q_r.rb] = q_r.rl;
         q_nxt.rb = q_r.rb + 4'h1;
         if (q_r.rb == 4'h0 && q_r.rl) begin
            q_nxt.ron = 1'b0;
         end else if (q_r.rb == rn) begin
            // only the first stop bit is checked, as usual
            q_nxt.ron = 1'b0;
            q_nxt.rv = 1'b1;
            q_nxt.rd = q_r.rs[8:1];
            q_nxt.re = !q_r.rl ||
                       (pen && q_r.rs[9] != par_bit(q_r.rs[8:1], par_i));
         end
      end
      if (!q_r.ton) begin
         if (tx_go_i) begin
            q_nxt.ton = 1'b1;
            q_nxt.tb = 4'h0;
            q_nxt.tc = div_i - 17'h1;
            q_nxt.ts = pen ? {2'b11, par_bit(tx_d_i, par_i), tx_d_i, 1'b0}
                           : {3'b111, tx_d_i, 1'b0};
            q_nxt.txo = 1'b0;
         end
      end else if (q_r.tc != 17'h0) begin
         q_nxt.tc = q_r.tc - 17'h1;
      end else begin
         q_nxt.tc = div_i - 17'h1;
         q_nxt.tb = q_r.tb + 4'h1;
         q_nxt.ts = {1'b1, q_r.ts[11:1]};
         q_nxt.txo = q_r.ts[1];
         if (q_r.tb + 4'h1 == tn) begin
            q_nxt.ton = 1'b0;
            q_nxt.txo = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q_r <= '0;
         q_r.sy <= 3'h7;
         q_r.rl <= 1'b1;
         q_r.txo <= 1'b1;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign rx_v_o = q_r.rv;
   assign rx_d_o = q_r.rd;
   assign rx_err_o = q_r.re;
   assign rx_busy_o = q_r.ron;
   assign tx_busy_o = q_r.ton;
   assign tx_o = q_r.txo;
endmodule // uart_char
`default_nettype wire

/* src/modbus_rtu_slave_port.sv */
// serial request interpreter with command and status registers
// Operation
// - rtu frames over a two-wire half-duplex line, this end is slave
// - register address fields travel high byte first
// - register data travel low byte first
// - codes 4, 6, 16 and 23 are accepted and executed
// - illegal values get an exception reply with code three
// - command registers are numbers 1000 to 1007
// - status registers are numbers 2000 to 2007
// - register numbers appear in frames as plain binary
// - read reply: address, code, twice count, data, check
// - code 6 writes one command register and echoes the request
// - multi write reply: address, code, start, count, new check
// - every frame ends in the serial crc over all bytes before
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_port
   import mrtu_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        rx_i,
   output logic             tx_o,
   output logic             de_o
);
   typedef enum logic [3:0] {
      S_RX  = 4'b0001,
      S_EX  = 4'b0010,
      S_TX  = 4'b0100,
      S_END = 4'b1000
   } st_t;

   typedef struct packed {
      st_t              st;
      logic [31:0][7:0] fb;
      logic [5:0]       len;
      logic             bad;
      logic [15:0]      crc;
      logic [22:0]      gap;
      logic [5:0]       ti;
      logic [5:0]       tl;
      logic             tgo;
      logic [7:0]       td;
      logic [7:0][15:0] cmd;
      logic [7:0][15:0] sts;
      logic [3:0]       sid;
      logic [1:0]       par;
      logic             stp2;
      logic [16:0]      div;
      logic [31:0]      rdata;
      logic [15:0]      nok;
      logic [15:0]      nbad;
   } core_t;

   core_t       q_r;
   core_t       q_nxt;
   logic        rx_v;
   logic [7:0]  rx_d;
   logic        rx_err;
   logic        rx_busy;
   logic        tx_busy;
   logic [3:0]  cbits;
   logic [5:0]  gbits;
   logic [22:0] lim;
   logic        fend;
   logic        good;
   logic [7:0]  fc;
   logic [15:0] a0;
   logic [15:0] n0;
   logic [15:0] wa;
   logic [15:0] wn;
   logic [15:0] ln;
   logic        ex_ok;
   logic [7:0]  tsel;
   logic        is_cmd;
   logic        is_sts;
   logic        map_ok;
   logic        wr;

   function automatic logic in_rng(input logic [15:0] a,
                                   input logic [15:0] c,
                                   input logic [15:0] b);
      return (c != 16'h0) && (c <= NREG) && (a >= b) &&
             ({1'b0, a} + {1'b0, c} <= {1'b0, b} + {1'b0, NREG});
   endfunction

   function automatic logic [15:0] word(input logic [7:0] hi,
                                        input logic [7:0] lo);
      return {hi, lo};
   endfunction

   uart_char u_char (
      .clk_i     (clk_i),
      .resetn_i  (resetn_i),
      .div_i     (q_r.div),
      .par_i     (q_r.par),
      .stp2_i    (q_r.stp2),
      .rx_i      (rx_i),
      .rx_v_o    (rx_v),
      .rx_d_o    (rx_d),
      .rx_err_o  (rx_err),
      .rx_busy_o (rx_busy),
      .tx_go_i   (q_r.tgo),
      .tx_d_i    (q_r.td),
      .tx_busy_o (tx_busy),
      .tx_o      (tx_o)
   );

   always_comb begin
      // character length in bits, then gap in bit times
      cbits = 4'hA + {3'h0, q_r.par != PAR_NONE} + {3'h0, q_r.stp2};
      gbits = 6'((GAP_HALF * cbits + 8'h01) >> 1);
      lim = 23'(q_r.div) * {17'h0, gbits};
      fend = (q_r.st == S_RX) && (q_r.len != 6'h0) && !rx_busy &&
             (q_r.gap >= lim);
      good = !q_r.bad && (q_r.len >= 6'h4) &&
             (q_r.crc == 16'h0000) &&
             (q_r.fb[0] == {4'h0, q_r.sid});
      fc = q_r.fb[1];
      a0 = word(q_r.fb[2], q_r.fb[3]);
      n0 = word(q_r.fb[4], q_r.fb[5]);
      wa = word(q_r.fb[6], q_r.fb[7]);
      wn = word(q_r.fb[8], q_r.fb[9]);
      ln = {10'h000, q_r.len};
      tsel = (q_r.ti < q_r.tl) ? q_r.fb[q_r.ti[4:0]] :
             (q_r.ti == q_r.tl) ? q_r.crc[7:0] : q_r.crc[15:8];
      is_cmd = (paddr_i[7:5] == A_CMD);
      is_sts = (paddr_i[7:5] == A_STS);
      map_ok = (paddr_i[1:0] == 2'h0) &&
               (is_cmd || is_sts || paddr_i == A_CFG ||
                paddr_i == A_DIV || paddr_i == A_CNT ||
                paddr_i == A_STAT);
      wr = psel_i && penable_i && pwrite_i && map_ok;
      ex_ok = 1'b0;
      // register numbers map straight to binary, base low bits are 0
      case (fc)
         FC_RD: begin
            ex_ok = (ln == 16'h0008) &&
                    in_rng(a0, n0, STS_BASE);
         end
         FC_W1: begin
            ex_ok = (ln == 16'h0008) &&
                    in_rng(a0, 16'h0001, CMD_BASE);
         end
         FC_WN: begin
            ex_ok = in_rng(a0, n0, CMD_BASE) &&
                    ({8'h00, q_r.fb[6]} == {n0[14:0], 1'b0}) &&
                    (ln == 16'h0009 + {n0[14:0], 1'b0});
         end
         FC_RW: begin
            ex_ok = in_rng(a0, n0, STS_BASE) &&
                    in_rng(wa, wn, CMD_BASE) &&
                    ({8'h00, q_r.fb[10]} == {wn[14:0], 1'b0}) &&
                    (ln == 16'h000D + {wn[14:0], 1'b0});
         end
         default: begin
            ex_ok = 1'b0;
         end
      endcase
   end

   always_comb begin
      q_nxt = q_r;
      q_nxt.tgo = 1'b0;
      // software side: setup phase latches read data
      if (psel_i && !penable_i && !pwrite_i) begin
         q_nxt.rdata = 32'h0000_0000;
         if (is_cmd) begin
            q_nxt.rdata = {16'h0000, q_r.cmd[paddr_i[4:2]]};
         end else if (is_sts) begin
            q_nxt.rdata = {16'h0000, q_r.sts[paddr_i[4:2]]};
         end else if (paddr_i == A_CFG) begin
            q_nxt.rdata = {25'h0, q_r.stp2, q_r.par, q_r.sid};
         end else if (paddr_i == A_DIV) begin
            q_nxt.rdata = {15'h0, q_r.div};
         end else if (paddr_i == A_CNT) begin
            q_nxt.rdata = {q_r.nbad, q_r.nok};
         end else if (paddr_i == A_STAT) begin
            q_nxt.rdata = {22'h0, q_r.len, q_r.st};
         end
      end
      if (wr) begin
         if (is_sts) begin
            q_nxt.sts[paddr_i[4:2]] = pwdata_i[15:0];
         end else if (paddr_i == A_CFG) begin
            // out of range ids and parity codes are ignored
            if (pwdata_i[3:0] != 4'h0 && pwdata_i[3:0] <= SID_MAX) begin
               q_nxt.sid = pwdata_i[3:0];
            end
            if (pwdata_i[5:4] != 2'h3) begin
               q_nxt.par = pwdata_i[5:4];
            end
            q_nxt.stp2 = pwdata_i[6];
         end else if (paddr_i == A_DIV) begin
            if (pwdata_i[16:0] >= DIV_MIN &&
                pwdata_i[16:0] <= DIV_MAX &&
                pwdata_i[31:17] == 15'h0) begin
               q_nxt.div = pwdata_i[16:0];
            end
         end
      end
      case (q_r.st)
         S_RX: begin
            if (rx_v || rx_busy) begin
               q_nxt.gap = 23'h0;
            end else if (q_r.gap < lim) begin
               q_nxt.gap = q_r.gap + 23'h1;
            end
            if (rx_v) begin
               if (q_r.len < FB_LAST) begin
                  q_nxt.fb[q_r.len[4:0]] = rx_d;
                  q_nxt.len = q_r.len + 6'h1;
                  q_nxt.crc = crc_upd(q_r.crc, rx_d);
               end else begin
                  q_nxt.bad = 1'b1;
               end
               if (rx_err) begin
                  q_nxt.bad = 1'b1;
               end
            end else if (fend) begin
               if (good) begin
                  q_nxt.st = S_EX;
                  q_nxt.nok = q_r.nok + 16'h1;
               end else begin
                  // dropped without a word on the line
                  q_nxt.len = 6'h0;
                  q_nxt.crc = CRC_INIT;
                  q_nxt.bad = 1'b0;
                  if (q_r.fb[0] == {4'h0, q_r.sid}) begin
                     q_nxt.nbad = q_r.nbad + 16'h1;
                  end
               end
            end
         end
         S_EX: begin
            q_nxt.st = S_TX;
            q_nxt.ti = 6'h0;
            q_nxt.crc = CRC_INIT;
            q_nxt.tl = 6'h06;
            if (!ex_ok) begin
               q_nxt.fb[1] = fc | EXC_FLAG;
               q_nxt.fb[2] = EXC_VAL;
               q_nxt.tl = 6'h03;
            end else begin
               if (fc == FC_W1) begin
                  q_nxt.cmd[a0[2:0]] = word(q_r.fb[5], q_r.fb[4]);
               end
               // writes come from the request, reads from status
               for (int i = 0; i < 8; i++) begin
                  if (fc == FC_WN && 16'(i) < n0) begin
                     q_nxt.cmd[3'(a0[2:0] + 3'(i))] =
                        word(q_r.fb[8 + 2 * i], q_r.fb[7 + 2 * i]);
                  end
                  if (fc == FC_RW && 16'(i) < wn) begin
                     q_nxt.cmd[3'(wa[2:0] + 3'(i))] =
                        word(q_r.fb[12 + 2 * i], q_r.fb[11 + 2 * i]);
                  end
                  if ((fc == FC_RD || fc == FC_RW) && 16'(i) < n0) begin
                     q_nxt.fb[3 + 2 * i] =
                        q_r.sts[3'(a0[2:0] + 3'(i))][7:0];
                     q_nxt.fb[4 + 2 * i] =
                        q_r.sts[3'(a0[2:0] + 3'(i))][15:8];
                  end
               end
               if (fc == FC_RD || fc == FC_RW) begin
                  q_nxt.fb[2] = {n0[6:0], 1'b0};
                  q_nxt.tl = 6'h03 + {n0[4:0], 1'b0};
               end
               // multi write replies with the first six bytes only
            end
         end
         S_TX: begin
            if (!tx_busy && !q_r.tgo) begin
               q_nxt.tgo = 1'b1;
               q_nxt.td = tsel;
               if (q_r.ti < q_r.tl) begin
                  q_nxt.crc = crc_upd(q_r.crc, tsel);
               end
               q_nxt.ti = q_r.ti + 6'h1;
               if (q_r.ti == q_r.tl + 6'h1) begin
                  q_nxt.st = S_END;
               end
            end
         end
         S_END: begin
            // keep driving until the last stop bit has left
            if (!tx_busy && !q_r.tgo) begin
               q_nxt.st = S_RX;
               q_nxt.len = 6'h0;
               q_nxt.crc = CRC_INIT;
               q_nxt.bad = 1'b0;
               q_nxt.gap = 23'h0;
            end
         end
         default: begin
            q_nxt.st = S_RX;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         q_r <= '0;
         q_r.st <= S_RX;
         q_r.crc <= CRC_INIT;
         q_r.sid <= SID_RST;
         q_r.par <= PAR_NONE;
         q_r.div <= DIV_RST;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign prdata_o = q_r.rdata;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !map_ok;
   assign de_o = (q_r.st == S_TX) || (q_r.st == S_END);

   // assertion helpers
   logic [31:0][7:0] fb_d;
   logic [7:0][15:0] cmd_d;
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fb_d <= '0;
      end else begin
         fb_d <= q_r.fb;
      end
   end
   assign cmd_d = q_r.cmd;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_drop;
      fend && !good;
   endsequence
   sequence s_quiet;
      (q_r.st == S_RX && !de_o) [*4];
   endsequence
   sequence s_first_byte;
      q_r.st == S_TX ##[0:3] q_r.tgo;
   endsequence

   property p_idle_high;
      !de_o |-> tx_o;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("line not idle while released");

   property p_drop;
      s_drop |=> s_quiet;
   endproperty
   a_drop: assert property (p_drop)
      else $error("dropped frame answered");

   property p_own_id;
      q_r.st == S_EX |-> q_r.fb[0] == {4'h0, q_r.sid};
   endproperty
   a_own_id: assert property (p_own_id)
      else $error("frame for other slave executed");

   property p_exc;
      q_r.st == S_EX && !ex_ok |=> q_r.fb[1] == (fb_d[1] | EXC_FLAG)
         && q_r.fb[2] == EXC_VAL && q_r.tl == 6'h03;
   endproperty
   a_exc: assert property (p_exc)
      else $error("bad exception reply");

   property p_rd;
      q_r.st == S_EX && ex_ok && fc == FC_RD |=>
         q_r.fb[2] == {fb_d[5][6:0], 1'b0} &&
         q_r.tl == 6'h03 + {fb_d[5][4:0], 1'b0};
   endproperty
   a_rd: assert property (p_rd)
      else $error("read reply length wrong");

   property p_w1;
      q_r.st == S_EX && ex_ok && fc == FC_W1 |=>
         cmd_d[fb_d[3][2:0]] == {fb_d[5], fb_d[4]} && q_r.tl == 6'h06;
   endproperty
   a_w1: assert property (p_w1)
      else $error("single write not stored or echoed");

   property p_wn;
      q_r.st == S_EX && ex_ok && fc == FC_WN |=>
         q_r.tl == 6'h06 && q_r.fb[5] == fb_d[5];
   endproperty
   a_wn: assert property (p_wn)
      else $error("multi write reply wrong");

   property p_crc_lo;
      q_r.st == S_TX && !tx_busy && !q_r.tgo && q_r.ti == q_r.tl
         |=> q_r.tgo && q_r.td == $past(q_r.crc[7:0]);
   endproperty
   a_crc_lo: assert property (p_crc_lo)
      else $error("check code low byte not sent");

   property p_start_tx;
      q_r.st == S_EX |=> s_first_byte;
   endproperty
   a_start_tx: assert property (p_start_tx)
      else $error("accepted request not answered");
endmodule // modbus_rtu_slave_port
`default_nettype wire

/* test/rtu_master_model.sv */
// serial bus master model: sends requests, gathers replies
`timescale 1ns/1ps
`default_nettype none
module rtu_master_model (
   input  wire logic clk_i,
   input  wire logic tx_i,
   output logic      rx_o
);
   int         div = 868;
   logic       pen = 1'b0;
   logic       podd = 1'b0;
   logic       stp2 = 1'b0;
   logic [7:0] got[$];
   // own crc, kept apart from the design's copy
   function automatic logic [15:0] crc(input logic [7:0] b[$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (b[i]) begin
         c ^= {8'h00, b[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      return c;
   endfunction
   // start, eight data bits lsb first, optional parity, one or two stops
   task automatic put(input logic [11:0] s, input int n);
      for (int i = 0; i < n; i++) begin
         rx_o <= s[i];
         repeat (div) @(posedge clk_i);
      end
   endtask
   // crc low byte first; bad flips one crc bit on purpose
   task automatic send(input logic [7:0] b[$], input logic bad);
      logic [15:0] c;
      c = crc(b) ^ {15'h0000, bad};
      b.push_back(c[7:0]);
      b.push_back(c[15:8]);
      foreach (b[i])
         put(pen ? {2'b11, (^b[i] ^ podd), b[i], 1'b0}
                 : {3'b111, b[i], 1'b0}, 10 + pen + stp2);
      repeat (div * 40) @(posedge clk_i);
   endtask
   initial begin
      rx_o = 1'b1;
      forever begin
         logic [7:0] d;
         @(negedge tx_i);
         repeat (div + div / 2) @(posedge clk_i);
         for (int i = 0; i < 8; i++) begin
            d[i] = tx_i;
            repeat (div) @(posedge clk_i);
         end
         got.push_back(d);
      end
   end
endmodule // rtu_master_model
`default_nettype wire

/* test/modbus_rtu_slave_port_tb.sv */
// self-checking bench of the serial slave port
`timescale 1ns/1ps
`default_nettype none
module modbus_rtu_slave_port_tb
   import mrtu_pkg::*;
();
   logic        clk_i     = 1'b0;
   logic        resetn_i  = 1'b0;
   logic        psel_i    = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i  = 1'b0;
   logic [7:0]  paddr_i   = 8'h00;
   logic [31:0] pwdata_i  = 32'h0000_0000;
   logic [31:0] prdata_o, rd;
   logic        pready_o, pslverr_o, rx_i, tx_o, de_o, err;
   int          num_errors = 0;
   int          comparisons = 0;
   int          cycles = 0;
   modbus_rtu_slave_port i_dut (.clk_i(clk_i), .resetn_i(resetn_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
      .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i),
      .tx_o(tx_o), .de_o(de_o));
   rtu_master_model i_master (.clk_i(clk_i), .tx_i(tx_o), .rx_o(rx_i));
   initial forever #5 clk_i = ~clk_i;
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      comparisons++;
      if (got !== exp)
         $display("BAD %s expected %h seen %h", what, exp, got);
      if (got !== exp)
         num_errors++;
   endtask
   // no wait state count assumed: loops on pready
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // empty queue means the frame must be dropped
   task automatic reply(logic [7:0] b[$]);
      logic [15:0] c;
      int          n;
      c = i_master.crc(b);
      if (b.size() > 0) begin
         b.push_back(c[7:0]);
         b.push_back(c[15:8]);
      end
      n = 0;
      while (n++ < 2000 || i_master.got.size() < b.size() && n < 9000)
         @(posedge clk_i);
      chk("reply length", b.size(), i_master.got.size());
      foreach (b[i])
         if (i < i_master.got.size())
            chk("reply byte", b[i], i_master.got[i]);
      chk("driver enable", 32'h0, de_o);
      i_master.got.delete();
   endtask
   task automatic t_setup;
      apb(1'b0, A_CFG, 32'h0);
      chk("cfg reset", 32'h9, rd[6:0]);
      apb(1'b0, A_DIV, 32'h0);
      chk("div reset", 32'd868, rd[16:0]);
      apb(1'b0, 8'h30, 32'h0);
      chk("unmapped error", 32'h1, err);
      apb(1'b1, A_DIV, 32'd9);
      i_master.div = 9;
      apb(1'b1, 8'h60, 32'h00F0);
      apb(1'b1, 8'h7C, 32'hA55A);
      $display("setup done");
   endtask
   task automatic t_read;
      i_master.send('{8'h09, 8'h04, 8'h07, 8'hD0, 8'h00, 8'h02},
                    0);
      reply('{8'h09, 8'h04, 8'h04, 8'hF0, 8'h00, 8'h00, 8'h00});
      i_master.send('{8'h09, 8'h04, 8'h07, 8'hD7, 8'h00, 8'h01},
                    0);
      reply('{8'h09, 8'h04, 8'h02, 8'h5A, 8'hA5});
      $display("read done");
   endtask
   task automatic t_write;
      i_master.send('{8'h09, 8'h06, 8'h03, 8'hE9, 8'h00, 8'h19}, 0);
      reply('{8'h09, 8'h06, 8'h03, 8'hE9, 8'h00, 8'h19});
      apb(1'b0, 8'h44, 32'h0);
      chk("cmd 1001", 32'h1900, rd[15:0]);
      i_master.send('{8'h09, 8'h10, 8'h03, 8'hEE, 8'h00, 8'h02, 8'h04,
                      8'h11, 8'h22, 8'h33, 8'h44}, 0);
      reply('{8'h09, 8'h10, 8'h03, 8'hEE, 8'h00, 8'h02});
      apb(1'b0, 8'h5C, 32'h0);
      chk("cmd 1007", 32'h4433, rd[15:0]);
      i_master.send('{8'h09, 8'h17, 8'h07, 8'hD0, 8'h00, 8'h01, 8'h03,
                      8'hE8, 8'h00, 8'h01, 8'h02, 8'h55, 8'h66}, 0);
      reply('{8'h09, 8'h17, 8'h02, 8'hF0, 8'h00});
      apb(1'b0, 8'h40, 32'h0);
      chk("cmd 1000", 32'h6655, rd[15:0]);
      $display("write done");
   endtask
   task automatic t_fault;
      i_master.send('{8'h05, 8'h04, 8'h07, 8'hD0, 8'h00, 8'h01}, 0);
      reply('{});
      i_master.send('{8'h09, 8'h04, 8'h07, 8'hD0, 8'h00, 8'h01}, 1);
      reply('{});
      i_master.send('{8'h09, 8'h04, 8'h07, 8'hD8, 8'h00, 8'h01}, 0);
      reply('{8'h09, 8'h84, 8'h03});
      i_master.send('{8'h09, 8'h03, 8'h07, 8'hD0, 8'h00, 8'h01}, 0);
      reply('{8'h09, 8'h83, 8'h03});
      i_master.send('{8'h09, 8'h06, 8'h07, 8'hD0, 8'h00, 8'h01}, 0);
      reply('{8'h09, 8'h86, 8'h03});
      // eight good frames for us, one bad check code for us
      apb(1'b0, A_CNT, 32'h0);
      chk("frame counts", 32'h0001_0008, rd);
      $display("fault done");
   endtask
   // even parity with two stop bits, a parity mismatch, then odd parity with two stop bits
   task automatic t_parity;
      apb(1'b1, A_CFG, 32'h0000_0069);
      apb(1'b0, A_CFG, 32'h0);
      chk("cfg even", 32'h69, rd[6:0]);
      i_master.pen = 1'b1;
      i_master.stp2 = 1'b1;
      i_master.send('{8'h09, 8'h04, 8'h07, 8'hD0, 8'h00, 8'h01}, 0);
      reply('{8'h09, 8'h04, 8'h02, 8'hF0, 8'h00});
      i_master.podd = 1'b1;
      i_master.send('{8'h09, 8'h04, 8'h07, 8'hD0, 8'h00, 8'h01}, 0);
      reply('{});
      apb(1'b1, A_CFG, 32'h0000_0059);
      i_master.send('{8'h09, 8'h04, 8'h07, 8'hD0, 8'h00, 8'h01}, 0);
      reply('{8'h09, 8'h04, 8'h02, 8'hF0, 8'h00});
      $display("parity done");
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      t_setup();
      t_read();
      t_write();
      t_fault();
      t_parity();
      test_done();
   end
endmodule // modbus_rtu_slave_port_tb
`default_nettype wire
